// ==== ftimer_flags.sv ====
// Free-running timer with capture, compare and overflow flags, their enables and an APB slave.
//
// Behaviour
// - Enable register resets to 01 on reset, standby.
// - Enable bit 0 reads one, ignores writes.
// - Capture requests A-D are flag AND enable.
// - Compare requests A, B are flag AND enable.
// - Wrap request is wrap flag AND enable.
// - Flag register resets to 00 on reset, standby.
// - Flags clear by writing zero; bit 0 plain.
// - Zero clears only flags previously read as one.
// - Capture A sets flag, optionally buffers into C.
// - Capture B sets flag, optionally buffers into D.
// - Capture C flag sets; no store when buffered.
// - Capture D flag sets; no store when buffered.
// - Compare A flag sets on counter match.
// - Compare B flag sets on counter match.
// - Wrap flag sets when counter wraps to zero.
// - Clear-on-compare-A bit clears counter on match.
// - Edge select zero falling, one rising.
`timescale 1ns/1ps
`default_nettype none
`include "ftimer_params.svh"

module ftimer_flags (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 standby,
	input  wire logic                 capture_in_a,
	input  wire logic                 capture_in_b,
	input  wire logic                 capture_in_c,
	input  wire logic                 capture_in_d,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic                      capture_a_irq,
	output logic                      capture_b_irq,
	output logic                      capture_c_irq,
	output logic                      capture_d_irq,
	output logic                      compare_a_irq,
	output logic                      compare_b_irq,
	output logic                      wrap_irq,
	output logic                      irq
);
	import ftimer_pkg::*;

	logic [1:0]      rst_sync_reg;
	logic            rst_int_b;
	timer_state_type state_reg;
	timer_state_type state_next;

	// Reset is released through two flops so that removal never races the clock.
	// Only the second flop feeds the design; the first may settle late.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_int_b = rst_sync_reg[1];

	// Per-cycle decode helpers; none of them holds state.
	logic [3:0]  pins;
	logic [3:0]  rise;
	logic [3:0]  fall;
	logic [3:0]  cap_event;
	logic [7:1]  hw_set;
	logic [7:1]  sw_clear;
	logic        match_a;
	logic        match_b;
	logic        clear_cnt;
	logic        wrapped;
	logic        bus_write;
	logic        bus_read;
	logic        buf_a;
	logic        buf_b;
	logic [31:0] rd_value;
	logic        rd_error;
	logic [7:0]  ien_w;
	logic        access_edge;
	logic        status_clear;

	// All state but the reset synchroniser is one flat record; the combinational block builds its next image.

	assign pins = {capture_in_d, capture_in_c, capture_in_b, capture_in_a};

	always_comb begin
		state_next = state_reg;

		// A transfer takes effect only at the edge that ends its access phase.
		access_edge  = psel && penable && state_reg.pready;
		bus_write    = access_edge && pwrite;
		bus_read     = access_edge && !pwrite;
		status_clear = bus_write && (paddr == `FT_OFS_EVENT_CLEAR);
		buf_a = state_reg.capture_ctl[`FT_BIT_BUFFER_A];
		buf_b = state_reg.capture_ctl[`FT_BIT_BUFFER_B];

		// Edge detection per capture input; index 0..3 is A..D.
		// Each pin is compared with its sample of the previous clock, so one edge is one event.
		for (int i = 0; i < 4; i++) begin
			rise[i] = pins[i] && !state_reg.pin_last[i];
			fall[i] = !pins[i] && state_reg.pin_last[i];
			cap_event[i] = state_reg.capture_ctl[7 - i] ? rise[i] : fall[i];
		end

		// In buffered mode differing edge selects make the primary input trigger on both edges.
		// Equal selects leave the single edge chosen above.
		if (buf_a && (state_reg.capture_ctl[7] != state_reg.capture_ctl[5])) begin
			cap_event[0] = rise[0] || fall[0];
		end

		if (buf_b && (state_reg.capture_ctl[6] != state_reg.capture_ctl[4])) begin
			cap_event[1] = rise[1] || fall[1];
		end
		state_next.pin_last = pins;

		// Counter, compare and wrap.
		// A software write of the counter further down overrides this step.
		match_a   = state_reg.up_counter == state_reg.compare_reg_a;
		match_b   = state_reg.up_counter == state_reg.compare_reg_b;
		clear_cnt = match_a && state_reg.flags_control[`FT_BIT_CLEAR_ON_A];
		wrapped   = !clear_cnt && (state_reg.up_counter == `FT_COUNTER_TOP);
		if (clear_cnt) begin
			state_next.up_counter = `FT_COUNTER_RESET;
		end else begin
			state_next.up_counter = state_reg.up_counter + 16'h0001;
		end

		// Capture register moves. The buffered copy reads the old register before the new
		// count lands, so both happen at the same edge without a race.
		if (cap_event[0]) begin
			if (buf_a) begin
				state_next.capture_reg[2] = state_reg.capture_reg[0];
			end
			state_next.capture_reg[0] = state_reg.up_counter;
		end

		if (cap_event[1]) begin
			if (buf_b) begin
				state_next.capture_reg[3] = state_reg.capture_reg[1];
			end
			state_next.capture_reg[1] = state_reg.up_counter;
		end

		if (cap_event[2] && !buf_a) begin
			state_next.capture_reg[2] = state_reg.up_counter;
		end

		if (cap_event[3] && !buf_b) begin
			state_next.capture_reg[3] = state_reg.up_counter;
		end

		// Compare flags set on every cycle of equality, not only on the first.
		hw_set = 7'h00;
		hw_set[`FT_BIT_CAPTURE_A] = cap_event[0];
		hw_set[`FT_BIT_CAPTURE_B] = cap_event[1];
		hw_set[`FT_BIT_CAPTURE_C] = cap_event[2];
		hw_set[`FT_BIT_CAPTURE_D] = cap_event[3];
		hw_set[`FT_BIT_COMPARE_A] = match_a;
		hw_set[`FT_BIT_COMPARE_B] = match_b;
		hw_set[`FT_BIT_WRAP]      = wrapped;

		// A read arms exactly the flags the processor saw as one.
		// The returned data, not the live flags, decide what a later zero may clear.
		if (bus_read && paddr == `FT_OFS_FLAGS_CONTROL) begin
			state_next.read_as_one = state_reg.read_as_one | state_reg.prdata[7:1];
		end

		// Register writes.
		sw_clear = 7'h00;
		ien_w = pwdata[7:0];
		ien_w[`FT_BIT_RESERVED_ONE] = 1'b1;
		if (bus_write) begin
			unique case (paddr)
				`FT_OFS_IRQ_ENABLE: begin
					state_next.irq_enable = ien_w;
				end
				`FT_OFS_FLAGS_CONTROL: begin
					// A write consumes the arming, so every clear needs a fresh read.
					sw_clear = ~pwdata[7:1] & state_reg.read_as_one;
					state_next.read_as_one = 7'h00;
					state_next.flags_control[`FT_BIT_CLEAR_ON_A] = pwdata[0];
				end
				`FT_OFS_COUNTER: begin
					state_next.up_counter = pwdata[15:0];
				end
				`FT_OFS_COMPARE_A: begin
					state_next.compare_reg_a = pwdata[15:0];
				end
				`FT_OFS_COMPARE_B: begin
					state_next.compare_reg_b = pwdata[15:0];
				end
				`FT_OFS_CAPTURE_CTL: begin
					state_next.capture_ctl = pwdata[7:0];
				end
				`FT_OFS_EVENT_ENABLE: begin
					state_next.event_enable = pwdata[7:1];
				end
				default: begin
					// Capture, status and clear words change no register here.
					sw_clear = sw_clear;
				end
			endcase
		end

		// Writing one never sets a flag; a same-cycle event survives the clear.
		// Losing an event would hide a capture that software has not yet seen.
		for (int b = 1; b < 8; b++) begin
			if (hw_set[b]) begin
				state_next.flags_control[b] = 1'b1;
			end else if (sw_clear[b]) begin
				state_next.flags_control[b] = 1'b0;
			end
		end

		// Sticky event status for the combined interrupt, same bit layout as the flags.
		// An event in the cycle of its clear keeps the bit, as for the flags.
		for (int b = 1; b < 8; b++) begin
			if (hw_set[b]) begin
				state_next.event_status[b] = 1'b1;
			end else if (status_clear && pwdata[b]) begin
				state_next.event_status[b] = 1'b0;
			end
		end

		// Requests are registered, so they trail the flags by one clock.
		state_next.request[7:4] = state_reg.flags_control[7:4] & state_reg.irq_enable[7:4];
		state_next.request[3:2] = state_reg.flags_control[3:2] & state_reg.irq_enable[3:2];
		state_next.request[1]   = state_reg.flags_control[1] & state_reg.irq_enable[1];
		// Only the status path feeds the combined line; the seven requests stay separate.
		state_next.irq = |(state_reg.event_status & state_reg.event_enable);

		// Read mux, sampled in the setup cycle.
		// Unmapped words answer with an error and zero data.
		rd_error = 1'b0;
		rd_value = 32'h0000_0000;
		unique case (paddr)
			`FT_OFS_IRQ_ENABLE: begin
				rd_value[7:0] = state_reg.irq_enable;
			end
			`FT_OFS_FLAGS_CONTROL: begin
				rd_value[7:0] = state_reg.flags_control;
			end
			`FT_OFS_COUNTER: begin
				rd_value[15:0] = state_reg.up_counter;
			end
			`FT_OFS_COMPARE_A: begin
				rd_value[15:0] = state_reg.compare_reg_a;
			end
			`FT_OFS_COMPARE_B: begin
				rd_value[15:0] = state_reg.compare_reg_b;
			end
			`FT_OFS_CAPTURE_CTL: begin
				rd_value[7:0] = state_reg.capture_ctl;
			end
			`FT_OFS_CAPTURE_A: begin
				rd_value[15:0] = state_reg.capture_reg[0];
			end
			`FT_OFS_CAPTURE_B: begin
				rd_value[15:0] = state_reg.capture_reg[1];
			end
			`FT_OFS_CAPTURE_C: begin
				rd_value[15:0] = state_reg.capture_reg[2];
			end
			`FT_OFS_CAPTURE_D: begin
				rd_value[15:0] = state_reg.capture_reg[3];
			end
			`FT_OFS_EVENT_STATUS: begin
				rd_value[7:1] = state_reg.event_status;
			end
			`FT_OFS_EVENT_CLEAR: begin
				rd_value = 32'h0000_0000;
			end
			`FT_OFS_EVENT_ENABLE: begin
				rd_value[7:1] = state_reg.event_enable;
			end
			default: begin
				rd_error = 1'b1;
			end
		endcase

		// Slave answers one cycle into the access phase.
		// No wait states: a slower register would need a second access state here.
		unique case (state_reg.phase)
			BUS_IDLE: begin
				state_next.pready  = 1'b0;
				state_next.pslverr = 1'b0;
				if (psel && !penable) begin
					state_next.phase   = BUS_ACCESS;
					state_next.pready  = 1'b1;
					state_next.pslverr = rd_error;
					// Read data is latched at setup; a flag that sets later waits for the next read.
					if (pwrite) begin
						state_next.prdata = 32'h0000_0000;
					end else begin
						state_next.prdata = rd_value;
					end
				end
			end
			BUS_ACCESS: begin
				state_next.phase   = BUS_IDLE;
				state_next.pready  = 1'b0;
				state_next.pslverr = 1'b0;
			end
		endcase

		// Standby returns the timer to its reset image; the bus side keeps running.
		// Event status and its enable survive standby, so a wake-up source is not lost.
		// Pin history also survives, so leaving standby makes no false edge.
		if (standby) begin
			state_next.irq_enable    = `FT_IRQ_ENABLE_RESET;
			state_next.flags_control = `FT_FLAGS_RESET;
			state_next.read_as_one   = 7'h00;
			state_next.up_counter    = `FT_COUNTER_RESET;
			state_next.compare_reg_a = `FT_COMPARE_RESET;
			state_next.compare_reg_b = `FT_COMPARE_RESET;
			state_next.capture_ctl   = `FT_CAPTURE_CTL_RESET;
			state_next.capture_reg   = {4{`FT_CAPTURE_RESET}};
			state_next.request       = 7'h00;
		end
	end

	// Only constants load under reset; the bus and the timer restart together.
	always_ff @(posedge clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			state_reg.irq_enable    <= `FT_IRQ_ENABLE_RESET;
			state_reg.flags_control <= `FT_FLAGS_RESET;
			state_reg.read_as_one   <= 7'h00;

			state_reg.up_counter    <= `FT_COUNTER_RESET;
			state_reg.compare_reg_a <= `FT_COMPARE_RESET;
			state_reg.compare_reg_b <= `FT_COMPARE_RESET;

			state_reg.capture_ctl   <= `FT_CAPTURE_CTL_RESET;
			state_reg.capture_reg   <= {4{`FT_CAPTURE_RESET}};
			state_reg.pin_last      <= 4'h0;

			state_reg.event_status  <= 7'h00;
			state_reg.event_enable  <= 7'h00;
			state_reg.request       <= 7'h00;
			state_reg.irq           <= 1'b0;
			state_reg.phase         <= BUS_IDLE;
			state_reg.prdata        <= 32'h0000_0000;
			state_reg.pready        <= 1'b0;
			state_reg.pslverr       <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Every output is a bit of the registered state, so none can glitch.
	assign prdata        = state_reg.prdata;
	assign pready        = state_reg.pready;
	assign pslverr       = state_reg.pslverr;

	// Requests trail their flags by one clock.
	assign capture_a_irq = state_reg.request[`FT_BIT_CAPTURE_A];
	assign capture_b_irq = state_reg.request[`FT_BIT_CAPTURE_B];
	assign capture_c_irq = state_reg.request[`FT_BIT_CAPTURE_C];
	assign capture_d_irq = state_reg.request[`FT_BIT_CAPTURE_D];
	assign compare_a_irq = state_reg.request[`FT_BIT_COMPARE_A];
	assign compare_b_irq = state_reg.request[`FT_BIT_COMPARE_B];
	assign wrap_irq      = state_reg.request[`FT_BIT_WRAP];
	assign irq           = state_reg.irq;

endmodule
`default_nettype wire

// ==== ftimer_params.svh ====
// Register offsets, field positions, reset values and the counter top value of the timer flag block.
`ifndef FTIMER_PARAMS_SVH
`define FTIMER_PARAMS_SVH

`define FT_OFS_IRQ_ENABLE    12'h000
`define FT_OFS_FLAGS_CONTROL 12'h004
`define FT_OFS_COUNTER       12'h008
`define FT_OFS_COMPARE_A     12'h00C
`define FT_OFS_COMPARE_B     12'h010
`define FT_OFS_CAPTURE_CTL   12'h014
`define FT_OFS_CAPTURE_A     12'h018
`define FT_OFS_CAPTURE_B     12'h01C
`define FT_OFS_CAPTURE_C     12'h020
`define FT_OFS_CAPTURE_D     12'h024
`define FT_OFS_EVENT_STATUS  12'h028
`define FT_OFS_EVENT_CLEAR   12'h02C
`define FT_OFS_EVENT_ENABLE  12'h030

`define FT_IRQ_ENABLE_RESET  8'h01
`define FT_FLAGS_RESET       8'h00
`define FT_COUNTER_RESET     16'h0000
`define FT_COMPARE_RESET     16'hFFFF
`define FT_CAPTURE_RESET     16'h0000
`define FT_CAPTURE_CTL_RESET 8'h00
`define FT_COUNTER_TOP       16'hFFFF

`define FT_BIT_CAPTURE_A     7
`define FT_BIT_CAPTURE_B     6
`define FT_BIT_CAPTURE_C     5
`define FT_BIT_CAPTURE_D     4
`define FT_BIT_COMPARE_A     3
`define FT_BIT_COMPARE_B     2
`define FT_BIT_WRAP          1
`define FT_BIT_CLEAR_ON_A    0
`define FT_BIT_RESERVED_ONE  0
`define FT_BIT_BUFFER_A      3
`define FT_BIT_BUFFER_B      2

`endif

// ==== ftimer_pkg.sv ====
// Types shared by the timer flag block.
package ftimer_pkg;

	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b00,
		BUS_ACCESS = 2'b01
	} bus_phase_type;

	typedef struct packed {
		logic [7:0]       irq_enable;
		logic [7:0]       flags_control;
		logic [7:1]       read_as_one;
		logic [15:0]      up_counter;
		logic [15:0]      compare_reg_a;
		logic [15:0]      compare_reg_b;
		logic [7:0]       capture_ctl;
		logic [3:0][15:0] capture_reg;
		logic [3:0]       pin_last;
		logic [7:1]       event_status;
		logic [7:1]       event_enable;
		logic [7:1]       request;
		logic             irq;
		bus_phase_type    phase;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
	} timer_state_type;

endpackage

// ==== ftimer_flags_sva.sv ====
// Port-level assertions for the timer flag block.
`timescale 1ns/1ps
`default_nettype none

module ftimer_flags_sva (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        standby,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic        capture_a_irq,
	input  wire logic        capture_b_irq,
	input  wire logic        capture_c_irq,
	input  wire logic        capture_d_irq,
	input  wire logic        compare_a_irq,
	input  wire logic        compare_b_irq,
	input  wire logic        wrap_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire logic rd_ok;
	assign rd_ok = pready && !pwrite && !pslverr;

	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	idle_ready_a: assert property (!psel |=> !pready)
		else $error("ready without request");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	err_data_a: assert property (pslverr |-> prdata == 32'h0)
		else $error("data on refused access");
	enable_bit0_a: assert property (rd_ok && paddr == 12'h000 |-> prdata[0])
		else $error("enable bit 0 read low");
	flags_width_a: assert property (rd_ok && paddr == 12'h004 |-> prdata[31:8] == 24'h0)
		else $error("flag register upper bits set");
	standby_capture_a: assert property (standby ##1 standby |=>
		!(capture_a_irq || capture_b_irq || capture_c_irq || capture_d_irq))
		else $error("capture request during standby");
	standby_compare_a: assert property (standby ##1 standby |=>
		!(compare_a_irq || compare_b_irq || wrap_irq))
		else $error("compare request during standby");

	cover property (pslverr);
	cover property (wrap_irq);
	cover property (capture_a_irq);
	cover property (standby ##1 standby);
endmodule

bind ftimer_flags ftimer_flags_sva chk (.clk(clk), .rst_b(rst_b), .standby(standby), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .capture_a_irq(capture_a_irq), .capture_b_irq(capture_b_irq),
	.capture_c_irq(capture_c_irq), .capture_d_irq(capture_d_irq),
	.compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq), .wrap_irq(wrap_irq));

`default_nettype wire

// ==== ftimer_pin_source.sv ====
// Model of the outside logic that drives the four capture pins.
`timescale 1ns/1ps
`default_nettype none

module ftimer_pin_source (
	input  wire logic       clk,
	output var  logic [3:0] pins
);
	initial pins = 4'h0;
	// Levels change just after an edge and stay for whole cycles, so each one is wide enough.
	task automatic drive(input logic [3:0] lvl, input int hold);
		@(posedge clk);
		pins <= lvl;
		repeat (hold) @(posedge clk);
	endtask
endmodule

`default_nettype wire

// ==== free_running_timer_flags_irq_test.sv ====
// Self-checking testbench for the timer flag block.
`timescale 1ns/1ps
`default_nettype none
`include "ftimer_params.svh"

module free_running_timer_flags_irq_test;
	localparam logic [11:0] EN = `FT_OFS_IRQ_ENABLE, FL = `FT_OFS_FLAGS_CONTROL;
	localparam logic [11:0] CNT = `FT_OFS_COUNTER, CTL = `FT_OFS_CAPTURE_CTL;
	logic        clk = 1'b0, rst_b, standby, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, r, old_a, old_b;
	logic        e;
	wire  logic [31:0] prdata;
	wire  logic [6:0]  irqs;
	wire  logic [3:0]  pins;
	wire  logic        pready, pslverr, irq;
	int          fails = 0, n_tests = 0;

	ftimer_pin_source src (.clk(clk), .pins(pins));
	ftimer_flags DUT (.clk(clk), .rst_b(rst_b), .standby(standby), .capture_in_a(pins[3]),
		.capture_in_b(pins[2]), .capture_in_c(pins[1]), .capture_in_d(pins[0]), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capture_a_irq(irqs[6]), .capture_b_irq(irqs[5]),
		.capture_c_irq(irqs[4]), .capture_d_irq(irqs[3]), .compare_a_irq(irqs[2]),
		.compare_b_irq(irqs[1]), .wrap_irq(irqs[0]), .irq(irq));

	always #5 clk = ~clk;

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// The request is held until pready is seen high; data is taken at that same edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			fails++;
			final_report;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask

	// The combined irq is registered one clock behind status and enable, so two edges are let pass.
	task automatic irq_is(input logic x);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'(x));
	endtask

	initial begin
		#100us;
		fails++;
		final_report;
	end

	initial begin
		{rst_b, standby, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rd(EN, 32'(`FT_IRQ_ENABLE_RESET));
		rd(FL, 32'(`FT_FLAGS_RESET));
		wr(EN, 32'hFE);
		rd(EN, 32'hFF);
		wr(EN, 32'h00);
		rd(EN, 32'h01);
		rd(12'h100, 32'h0);
		chk(32'(e), 32'h1);
		wr(CNT, 32'hFFE0);
		wr(`FT_OFS_COMPARE_A, 32'hFFF0);
		wr(`FT_OFS_COMPARE_B, 32'hFFF4);
		repeat (40) @(posedge clk);
		rd(FL, 32'h0E);
		wr(EN, 32'h0E);
		repeat (2) @(posedge clk);
		chk({24'h0, irqs, 1'b0}, 32'h0E);
		wr(FL, 32'hF7);
		wr(FL, 32'h00);
		rd(FL, 32'h06);
		chk({24'h0, irqs, 1'b0}, 32'h06);
		wr(FL, 32'hFF);
		rd(FL, 32'h07);
		wr(FL, 32'h01);
		wr(`FT_OFS_COMPARE_A, 32'h0010);
		wr(CNT, 32'h0);
		repeat (60) @(posedge clk);
		rd(FL, 32'h09);
		apb(1'b0, CNT, 32'h0);
		chk(32'(r <= 32'h10), 32'h1);
		wr(CNT, 32'h000E);
		wr(FL, 32'h01);
		rd(FL, 32'h09);
		wr(CTL, 32'hA0);
		src.drive(4'hF, 3);
		apb(1'b0, FL, 32'h0);
		chk(32'(r[7:4]), 32'hA);
		src.drive(4'h0, 3);
		apb(1'b0, FL, 32'h0);
		chk(32'(r[7:4]), 32'hF);
		apb(1'b0, `FT_OFS_CAPTURE_A, 32'h0);
		old_a = r;
		apb(1'b0, `FT_OFS_CAPTURE_B, 32'h0);
		old_b = r;
		wr(CTL, 32'hAC);
		src.drive(4'hF, 3);
		src.drive(4'h0, 3);
		rd(`FT_OFS_CAPTURE_C, old_a);
		rd(`FT_OFS_CAPTURE_D, old_b);
		wr(`FT_OFS_EVENT_ENABLE, 32'h80);
		irq_is(1'b1);
		wr(`FT_OFS_EVENT_ENABLE, 32'h00);
		irq_is(1'b0);
		wr(`FT_OFS_EVENT_ENABLE, 32'h80);
		wr(`FT_OFS_EVENT_CLEAR, 32'h80);
		irq_is(1'b0);
		apb(1'b0, `FT_OFS_EVENT_STATUS, 32'h0);
		chk(32'(r[7]), 32'h0);
		standby <= 1'b1;
		repeat (3) @(posedge clk);
		standby <= 1'b0;
		chk(32'(irqs), 32'h0);
		rd(EN, 32'h01);
		rd(FL, 32'h00);
		final_report;
	end
endmodule

`default_nettype wire
